// File: src/cgrx_pkg.sv
/*
 * Shared constants, register map and carrier types of the global receive block.
 * Assumes a 32-bit APB master and a CAN protocol core around the block.
 */
package cgrx_pkg;
	// ==========================================
	// Register offsets
	localparam logic [7:0] GLOBAL_CONFIG_LOW_OFS = 8'h00;
	localparam logic [7:0] GLOBAL_CONFIG_HIGH_OFS = 8'h04;
	localparam logic [7:0] COMMON_FIFO_CONFIG_LOW_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0c;
	// ==========================================
	// Global config low fields
	localparam int LEN_CHECK_BIT = 0;
	localparam int LEN_REPLACE_BIT = 1;
	localparam int SELF_RX_BIT = 2;
	localparam int CAN_CLK_SRC_BIT = 3;
	localparam int OVF_STORE_BIT = 4;
	localparam int TS_CLK_SRC_BIT = 5;
	localparam int RES_EXC_BIT = 6;
	localparam int CAP_SEL_LSB = 7;
	localparam int CFG_LOW_W = 9;
	localparam logic [CFG_LOW_W-1:0] CFG_LOW_RST = 9'h000;
	// Global config high and fifo config fields
	localparam int PRESC_W = 16;
	localparam logic [PRESC_W-1:0] PRESC_RST = 16'h0000;
	localparam int ITV_SRC_BIT = 0;
	localparam int ITV_TEN_BIT = 1;
	localparam logic [1:0] FIFO_CFG_RST = 2'h0;
	// Status fields
	localparam int TS_W = 16;
	localparam logic [TS_W-1:0] TS_RST = 16'h0000;
	localparam int ST_DLC_ERR_BIT = 16;
	localparam int ST_OVF_BIT = 17;
	localparam int ST_PEX_BIT = 18;
	// ==========================================
	// Timing and sizes
	localparam int PCLK_MHZ = 25;
	localparam int CAN_CLK_MAX_MHZ = 40;
	localparam logic [3:0] TEN_LAST = 4'h9;
	localparam int DATA_BYTES = 8;
	// ==========================================
	// Types
	typedef enum logic [1:0] {
		CAP_SOF = 2'b00,
		CAP_VALID = 2'b01,
		CAP_RES = 2'b10
	} cgrx_cap_type;
	typedef struct packed {
		logic id_match;
		logic self_frame;
		logic rule_self_frame_flag;
		logic [3:0] rx_dlc;
		logic [3:0] rule_dlc;
		logic [6:0] buf_bytes;
		logic [8*DATA_BYTES-1:0] data;
	} cgrx_rx_in_type;
	typedef struct packed {
		logic [3:0] dlc;
		logic [8*DATA_BYTES-1:0] data;
		logic [TS_W-1:0] stamp;
	} cgrx_rx_out_type;
endpackage : cgrx_pkg

// File: src/cgrx_top.sv
/*
 * Global receive functions: length filter and replacement, self-reception
 * rule selection, payload overflow, timestamp, interval prescaler, RES option.
 * Assumes APB from software and a protocol core giving one-cycle event strobes.
 */
`timescale 1ns/1ps
module cgrx_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_valid,
	input wire cgrx_pkg::cgrx_rx_in_type rx_in,
	input wire logic rx_sof,
	input wire logic rx_frame_valid,
	input wire logic rx_res_sample,
	input wire logic rx_is_fd,
	input wire logic tx_sof,
	input wire logic bit_tick,
	input wire logic classical_only,
	input wire logic ch_reset,
	input wire logic ch_halt,
	input wire logic res_recessive_fd,
	output logic rx_store,
	output cgrx_pkg::cgrx_rx_out_type rx_out,
	output logic rx_length_error,
	output logic rx_overflow_drop,
	output logic tx_history_write,
	output logic [cgrx_pkg::TS_W-1:0] tx_history_stamp,
	output logic [cgrx_pkg::TS_W-1:0] timestamp,
	output logic can_clk_crystal_sel,
	output logic interval_tick,
	output logic protocol_exception,
	output logic form_error_frame
);
	localparam int NB = cgrx_pkg::DATA_BYTES;

	// ==========================================
	// Length code to payload bytes
	function automatic logic [6:0] dlc_bytes(input logic [3:0] dlc);
		case (dlc)
			4'h9: dlc_bytes = 7'd12;
			4'ha: dlc_bytes = 7'd16;
			4'hb: dlc_bytes = 7'd20;
			4'hc: dlc_bytes = 7'd24;
			4'hd: dlc_bytes = 7'd32;
			4'he: dlc_bytes = 7'd48;
			4'hf: dlc_bytes = 7'd64;
			default: dlc_bytes = {3'h0, dlc};
		endcase
	endfunction : dlc_bytes

	// ==========================================
	// APB slave, no wait state, every answer still comes from a flop
	logic [cgrx_pkg::CFG_LOW_W-1:0] cfg_low_ff;
	logic [cgrx_pkg::PRESC_W-1:0] presc_ff;
	logic [1:0] fifo_cfg_ff;
	logic [2:0] sticky_ff;
	logic [cgrx_pkg::TS_W-1:0] ts_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic mapped;
	logic wr_acc;

	always_comb begin
		mapped = 1'b1;
		nxt_prdata = 32'h0000_0000;
		case (paddr)
			cgrx_pkg::GLOBAL_CONFIG_LOW_OFS: nxt_prdata = {23'h0, cfg_low_ff};
			cgrx_pkg::GLOBAL_CONFIG_HIGH_OFS: nxt_prdata = {16'h0, presc_ff};
			cgrx_pkg::COMMON_FIFO_CONFIG_LOW_OFS: nxt_prdata = {30'h0, fifo_cfg_ff};
			cgrx_pkg::STATUS_OFS: nxt_prdata = {13'h0, sticky_ff, ts_ff};
			default: mapped = 1'b0;
		endcase
	end

	assign wr_acc = psel && penable && pready_ff && pwrite && !pslverr_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= psel && !penable;
			pslverr_ff <= psel && !penable && !mapped;
			if (psel && !penable && !pwrite) begin
				prdata_ff <= nxt_prdata;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_low_ff <= cgrx_pkg::CFG_LOW_RST;
			presc_ff <= cgrx_pkg::PRESC_RST;
			fifo_cfg_ff <= cgrx_pkg::FIFO_CFG_RST;
		end else if (wr_acc) begin
			case (paddr)
				cgrx_pkg::GLOBAL_CONFIG_LOW_OFS: cfg_low_ff <= pwdata[cgrx_pkg::CFG_LOW_W-1:0];
				cgrx_pkg::GLOBAL_CONFIG_HIGH_OFS: presc_ff <= pwdata[cgrx_pkg::PRESC_W-1:0];
				cgrx_pkg::COMMON_FIFO_CONFIG_LOW_OFS: fifo_cfg_ff <= pwdata[1:0];
				default: ;
			endcase
		end
	end

	wire length_check_enable = cfg_low_ff[cgrx_pkg::LEN_CHECK_BIT];
	wire length_replace_enable = cfg_low_ff[cgrx_pkg::LEN_REPLACE_BIT];
	wire self_reception_enable = cfg_low_ff[cgrx_pkg::SELF_RX_BIT];
	wire ovf_store = cfg_low_ff[cgrx_pkg::OVF_STORE_BIT];
	wire ts_bit_clk = cfg_low_ff[cgrx_pkg::TS_CLK_SRC_BIT];
	wire res_exc_enable = cfg_low_ff[cgrx_pkg::RES_EXC_BIT];
	wire [1:0] cap_sel = cfg_low_ff[cgrx_pkg::CAP_SEL_LSB+1:cgrx_pkg::CAP_SEL_LSB];
	wire interval_timer_source_select = fifo_cfg_ff[cgrx_pkg::ITV_SRC_BIT];
	wire interval_divide_by_ten = fifo_cfg_ff[cgrx_pkg::ITV_TEN_BIT];

	// ==========================================
	// Receive filtering decisions
	logic rule_hit;
	logic len_short;
	logic do_replace;
	logic [3:0] keep_dlc;
	logic [6:0] keep_bytes;
	logic overflow;
	logic [8*NB-1:0] masked_data;

	always_comb begin
		// Own frames need self flag and global enable; others need flag clear
		if (rx_in.self_frame) begin
			rule_hit = rx_in.id_match && rx_in.rule_self_frame_flag && self_reception_enable;
		end else begin
			rule_hit = rx_in.id_match && !rx_in.rule_self_frame_flag;
		end
		// A zero rule length always passes
		len_short = length_check_enable && (rx_in.rule_dlc != 4'h0) && (rx_in.rx_dlc < rx_in.rule_dlc);
		do_replace = length_check_enable && length_replace_enable && (rx_in.rule_dlc != 4'h0);
		keep_dlc = do_replace ? rx_in.rule_dlc : rx_in.rx_dlc;
		overflow = dlc_bytes(keep_dlc) > rx_in.buf_bytes;
		keep_bytes = overflow ? rx_in.buf_bytes : dlc_bytes(keep_dlc);
	end

	// Zeroes bytes past the kept length, covering replacement and truncation
	genvar gi;
	generate
		for (gi = 0; gi < NB; gi++) begin : g_mask
			assign masked_data[8*gi +: 8] = (7'(gi) < keep_bytes) ? rx_in.data[8*gi +: 8] : 8'h00;
		end
	endgenerate

	// ==========================================
	// Receive result registers
	logic rx_store_ff;
	logic len_err_ff;
	logic ovf_drop_ff;
	cgrx_pkg::cgrx_rx_out_type rx_out_ff;
	logic [cgrx_pkg::TS_W-1:0] cap_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_store_ff <= 1'b0;
			len_err_ff <= 1'b0;
			ovf_drop_ff <= 1'b0;
			rx_out_ff <= '0;
		end else begin
			rx_store_ff <= rx_valid && rule_hit && !len_short && !(overflow && !ovf_store);
			len_err_ff <= rx_valid && rule_hit && len_short;
			ovf_drop_ff <= rx_valid && rule_hit && !len_short && overflow && !ovf_store;
			if (rx_valid && rule_hit) begin
				rx_out_ff.dlc <= keep_dlc;
				rx_out_ff.data <= masked_data;
				rx_out_ff.stamp <= cap_ff;
			end
		end
	end

	// ==========================================
	// Timestamp counter and capture
	logic ts_tick;
	logic rx_cap_evt;

	// Bit clock use is gated off outside classical-only operation
	assign ts_tick = ts_bit_clk ? (bit_tick && classical_only && !ch_reset && !ch_halt) : 1'b1;

	always_comb begin
		case (cgrx_pkg::cgrx_cap_type'(cap_sel))
			cgrx_pkg::CAP_VALID: rx_cap_evt = rx_frame_valid;
			cgrx_pkg::CAP_RES: rx_cap_evt = rx_is_fd ? rx_res_sample : rx_sof;
			default: rx_cap_evt = rx_sof;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ts_ff <= cgrx_pkg::TS_RST;
		end else if (ts_tick) begin
			ts_ff <= ts_ff + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_ff <= cgrx_pkg::TS_RST;
		end else if (rx_cap_evt) begin
			cap_ff <= ts_ff;
		end
	end

	logic tx_hist_ff;
	logic [cgrx_pkg::TS_W-1:0] tx_stamp_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_hist_ff <= 1'b0;
			tx_stamp_ff <= cgrx_pkg::TS_RST;
		end else begin
			tx_hist_ff <= tx_sof;
			if (tx_sof) begin
				tx_stamp_ff <= ts_ff;
			end
		end
	end

	// ==========================================
	// Interval timer prescaler
	logic [cgrx_pkg::PRESC_W-1:0] presc_cnt_ff;
	logic [3:0] ten_cnt_ff;
	logic itv_tick_ff;
	logic presc_wrap;

	// A zero prescaler behaves as divide by one
	assign presc_wrap = (presc_cnt_ff + 16'h0001 >= presc_ff);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_cnt_ff <= 16'h0000;
			ten_cnt_ff <= 4'h0;
			itv_tick_ff <= 1'b0;
		end else if (interval_timer_source_select) begin
			presc_cnt_ff <= 16'h0000;
			ten_cnt_ff <= 4'h0;
			itv_tick_ff <= 1'b0;
		end else begin
			itv_tick_ff <= 1'b0;
			if (presc_wrap) begin
				presc_cnt_ff <= 16'h0000;
				if (!interval_divide_by_ten || ten_cnt_ff == cgrx_pkg::TEN_LAST) begin
					ten_cnt_ff <= 4'h0;
					itv_tick_ff <= 1'b1;
				end else begin
					ten_cnt_ff <= ten_cnt_ff + 4'h1;
				end
			end else begin
				presc_cnt_ff <= presc_cnt_ff + 16'h0001;
			end
		end
	end

	// ==========================================
	// RES bit handling and sticky status
	logic pex_ff;
	logic form_err_ff;
	logic can_clk_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pex_ff <= 1'b0;
			form_err_ff <= 1'b0;
			can_clk_ff <= 1'b0;
		end else begin
			pex_ff <= res_recessive_fd && res_exc_enable;
			form_err_ff <= res_recessive_fd && !res_exc_enable;
			can_clk_ff <= cfg_low_ff[cgrx_pkg::CAN_CLK_SRC_BIT];
		end
	end

	// Write one clears; a new event in the same cycle wins
	logic [2:0] st_set;
	logic [2:0] st_clr;
	assign st_set = {pex_ff, ovf_drop_ff, len_err_ff};
	assign st_clr = (wr_acc && paddr == cgrx_pkg::STATUS_OFS) ? pwdata[cgrx_pkg::ST_PEX_BIT:cgrx_pkg::ST_DLC_ERR_BIT] : 3'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sticky_ff <= 3'h0;
		end else begin
			sticky_ff <= (sticky_ff & ~st_clr) | st_set;
		end
	end

	// ==========================================
	// Outputs
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign rx_store = rx_store_ff;
	assign rx_out = rx_out_ff;
	assign rx_length_error = len_err_ff;
	assign rx_overflow_drop = ovf_drop_ff;
	assign tx_history_write = tx_hist_ff;
	assign tx_history_stamp = tx_stamp_ff;
	assign timestamp = ts_ff;
	assign can_clk_crystal_sel = can_clk_ff;
	assign interval_tick = itv_tick_ff;
	assign protocol_exception = pex_ff;
	assign form_error_frame = form_err_ff;

	// ==========================================
	// Assertions
	sequence s_short_frame;
		rx_valid && rule_hit && length_check_enable && rx_in.rule_dlc != 4'h0 && rx_in.rx_dlc < rx_in.rule_dlc;
	endsequence
	sequence s_dropped;
		!rx_store_ff && len_err_ff;
	endsequence

	a_short_len_drop: assert property (@(posedge pclk) disable iff (!presetn)
		s_short_frame |=> s_dropped) else $error("short frame not dropped");
	a_no_check_keep: assert property (@(posedge pclk) disable iff (!presetn)
		rx_valid && rule_hit && !length_check_enable && !overflow |=> rx_store_ff && rx_out_ff.dlc == $past(rx_in.rx_dlc))
		else $error("unchecked frame length altered");
	a_replace_len: assert property (@(posedge pclk) disable iff (!presetn)
		rx_valid && rule_hit && do_replace && !len_short |=> rx_out_ff.dlc == $past(rx_in.rule_dlc))
		else $error("rule length not stored");
	a_other_node: assert property (@(posedge pclk) disable iff (!presetn)
		rx_valid && !rx_in.self_frame && rx_in.rule_self_frame_flag |=> !rx_store_ff && !len_err_ff)
		else $error("self rule matched foreign frame");
	a_self_off: assert property (@(posedge pclk) disable iff (!presetn)
		rx_valid && rx_in.self_frame && !self_reception_enable |=> !rx_store_ff)
		else $error("own frame stored while disabled");
	a_ovf_drop: assert property (@(posedge pclk) disable iff (!presetn)
		rx_valid && rule_hit && !len_short && overflow && !ovf_store |=> ovf_drop_ff && !rx_store_ff)
		else $error("overflow frame not dropped");
	a_ts_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		ts_tick && ts_ff == 16'hffff |=> ts_ff == 16'h0000) else $error("timestamp did not wrap");
	a_ts_halt: assert property (@(posedge pclk) disable iff (!presetn)
		ts_bit_clk && (ch_reset || ch_halt) |=> ts_ff == $past(ts_ff)) else $error("timestamp ran in halt");
	a_tx_stamp: assert property (@(posedge pclk) disable iff (!presetn)
		tx_sof |=> tx_hist_ff && tx_stamp_ff == $past(ts_ff)) else $error("tx stamp wrong");
	a_res_split: assert property (@(posedge pclk) disable iff (!presetn)
		res_recessive_fd |=> (pex_ff != form_err_ff) && (pex_ff == $past(res_exc_enable)))
		else $error("RES handling wrong");
endmodule : cgrx_top

// File: dv/cgrx_core_model.sv
/*
 * Far-side model: protocol core handing filtered frame results and the
 * nominal bit clock to the global receive block.
 * Assumes the bench calls send_frame and drives the event pulses itself.
 */
`timescale 1ns/1ps
module cgrx_core_model #(
	parameter int BIT_DIV = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	output logic bit_tick,
	output logic rx_valid,
	output cgrx_pkg::cgrx_rx_in_type rx_in
);
	logic [7:0] div_ff;
	// ==========================================
	// Nominal bit clock, free running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= 8'h00;
			bit_tick <= 1'b0;
		end else begin
			div_ff <= (div_ff == 8'(BIT_DIV - 1)) ? 8'h00 : div_ff + 8'h01;
			bit_tick <= (div_ff == 8'(BIT_DIV - 1));
		end
	end
	initial begin
		rx_valid = 1'b0;
		rx_in = '0;
	end
	// ==========================================
	// One frame result per call
	task automatic send_frame(input cgrx_pkg::cgrx_rx_in_type f);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_in <= f;
		@(posedge pclk);
		rx_valid <= 1'b0;
		// Stale payload inverted so a late sample cannot pass
		rx_in <= ~f;
	endtask : send_frame
endmodule : cgrx_core_model

// File: dv/cgrx_top_tb.sv
/*
 * Self-checking bench of the global receive block: APB registers, length
 * filter, self-reception, overflow, timestamp, interval prescaler, RES option.
 * Assumes cgrx_core_model as frame source and the package field positions.
 */
`timescale 1ns/1ps
module cgrx_top_tb;
	localparam logic [31:0] CK = 32'h1 << cgrx_pkg::LEN_CHECK_BIT;
	localparam logic [31:0] RP = 32'h1 << cgrx_pkg::LEN_REPLACE_BIT;
	localparam logic [31:0] SR = 32'h1 << cgrx_pkg::SELF_RX_BIT;
	localparam logic [31:0] XT = 32'h1 << cgrx_pkg::CAN_CLK_SRC_BIT;
	localparam logic [31:0] OV = 32'h1 << cgrx_pkg::OVF_STORE_BIT;
	localparam logic [31:0] TB = 32'h1 << cgrx_pkg::TS_CLK_SRC_BIT;
	localparam logic [31:0] RX = 32'h1 << cgrx_pkg::RES_EXC_BIT;
	localparam logic [31:0] C1 = 32'(cgrx_pkg::CAP_VALID) << cgrx_pkg::CAP_SEL_LSB;
	localparam logic [31:0] C2 = 32'(cgrx_pkg::CAP_RES) << cgrx_pkg::CAP_SEL_LSB;
	localparam logic [7:0] GL = cgrx_pkg::GLOBAL_CONFIG_LOW_OFS;
	localparam logic [7:0] GH = cgrx_pkg::GLOBAL_CONFIG_HIGH_OFS;
	localparam logic [7:0] FC = cgrx_pkg::COMMON_FIFO_CONFIG_LOW_OFS;
	localparam logic [63:0] D = 64'h8877665544332211;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, rx_valid, bit_tick, rx_store, rx_length_error, rx_overflow_drop, e;
	logic tx_history_write, can_clk_crystal_sel, interval_tick, protocol_exception, form_error_frame;
	logic rx_sof = 1'b0, rx_frame_valid = 1'b0, rx_res_sample = 1'b0, rx_is_fd = 1'b0, tx_sof = 1'b0;
	logic classical_only = 1'b0, ch_reset = 1'b0, ch_halt = 1'b0, res_recessive_fd = 1'b0;
	logic [15:0] tx_history_stamp, timestamp, t0, t1;
	cgrx_pkg::cgrx_rx_in_type rx_in;
	cgrx_pkg::cgrx_rx_out_type rx_out;
	int n_fail = 0, n_checks = 0;
	// Stands for the peripheral clock, run at half the main select clock
	always #20 pclk = ~pclk;
	cgrx_top i_cgrx_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
		.rx_in(rx_in), .rx_sof(rx_sof), .rx_frame_valid(rx_frame_valid), .rx_res_sample(rx_res_sample),
		.rx_is_fd(rx_is_fd), .tx_sof(tx_sof), .bit_tick(bit_tick), .classical_only(classical_only),
		.ch_reset(ch_reset), .ch_halt(ch_halt), .res_recessive_fd(res_recessive_fd), .rx_store(rx_store),
		.rx_out(rx_out), .rx_length_error(rx_length_error), .rx_overflow_drop(rx_overflow_drop),
		.tx_history_write(tx_history_write), .tx_history_stamp(tx_history_stamp), .timestamp(timestamp),
		.can_clk_crystal_sel(can_clk_crystal_sel), .interval_tick(interval_tick),
		.protocol_exception(protocol_exception), .form_error_frame(form_error_frame));
	cgrx_core_model i_cgrx_core_model (.pclk(pclk), .presetn(presetn), .bit_tick(bit_tick), .rx_valid(rx_valid),
		.rx_in(rx_in));
	// ==========================================
	// Reporting
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [83:0] seen, input logic [83:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tmo();
		n_fail++;
		$display("Error %0t: wait ran out", $time);
		stop_test();
	endtask : tmo
	// ==========================================
	// Bus and stimulus tasks
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic er);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 20) tmo();
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, q, e);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] d);
		apb(1'b0, a, 32'h0, q, e);
		chk({e, q}, {1'b0, d});
	endtask : rdc
	task automatic ev(input int k, output logic [15:0] t);
		@(posedge pclk);
		case (k)
			0: rx_sof <= 1'b1;
			1: rx_frame_valid <= 1'b1;
			2: rx_res_sample <= 1'b1;
			3: tx_sof <= 1'b1;
			default: res_recessive_fd <= 1'b1;
		endcase
		#1 t = timestamp;
		@(posedge pclk);
		rx_sof <= 1'b0;
		rx_frame_valid <= 1'b0;
		rx_res_sample <= 1'b0;
		tx_sof <= 1'b0;
		res_recessive_fd <= 1'b0;
		#1;
	endtask : ev
	function automatic logic [63:0] msk(input logic [63:0] d, input int n);
		msk = d;
		for (int i = n; i < 8; i++) msk[8*i +: 8] = 8'h00;
	endfunction : msk
	task automatic rx(input logic s, fl, input logic [3:0] d, r, input logic [6:0] b, input logic st,
		input logic [3:0] dl, input int nb, input logic er, ov);
		i_cgrx_core_model.send_frame('{1'b1, s, fl, d, r, b, D});
		#1;
		chk({rx_store, rx_length_error, rx_overflow_drop}, {st, er, ov});
		if (st) chk({rx_out.dlc, rx_out.data}, {dl, msk(D, nb)});
	endtask : rx
	task automatic cap(input int a, input int b);
		ev(a, t0);
		ev(b, t1);
		rx(1'b0, 1'b0, 4'h1, 4'h0, 7'h40, 1'b1, 4'h1, 1, 1'b0, 1'b0);
		chk(rx_out.stamp, t0);
	endtask : cap
	task automatic tsrun(input logic [15:0] inc);
		@(posedge pclk);
		#1 t0 = timestamp;
		repeat (8) @(posedge pclk);
		#1 chk(timestamp, 16'(t0 + inc));
	endtask : tsrun
	task automatic gap(input int n);
		int i, hits, last, g;
		hits = 0;
		last = 0;
		g = 0;
		for (i = 0; i < 800 && hits < 3; i++) begin
			@(posedge pclk);
			if (interval_tick === 1'b1) begin
				hits++;
				g = i - last;
				last = i;
			end
		end
		// First gap may straddle the reconfiguration
		chk(hits < 3 ? 0 : g, n);
	endtask : gap
	initial begin
		repeat (99000) @(posedge pclk);
		tmo();
	end
	// ==========================================
	// Main sequence
	initial begin
		int i;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rdc(GL, 32'h0);
		rdc(GH, 32'h0);
		rdc(FC, 32'h0);
		apb(1'b1, 8'h10, 32'h0000ffff, q, e);
		chk(e, 1'b1);
		wr(GH, 32'h00001234);
		rdc(GH, 32'h00001234);
		wr(GL, XT);
		@(posedge pclk);
		#1 chk(can_clk_crystal_sel, 1'b1);
		$display("test registers done");
		wr(GL, RP);
		rx(1'b0, 1'b0, 4'h2, 4'h5, 7'h40, 1'b1, 4'h2, 2, 1'b0, 1'b0);
		wr(GL, CK);
		rx(1'b0, 1'b0, 4'h2, 4'h5, 7'h40, 1'b0, 4'h0, 0, 1'b1, 1'b0);
		rx(1'b0, 1'b0, 4'h6, 4'h5, 7'h40, 1'b1, 4'h6, 6, 1'b0, 1'b0);
		wr(GL, CK | RP);
		rx(1'b0, 1'b0, 4'h6, 4'h5, 7'h40, 1'b1, 4'h5, 5, 1'b0, 1'b0);
		rx(1'b0, 1'b0, 4'h6, 4'h0, 7'h40, 1'b1, 4'h6, 6, 1'b0, 1'b0);
		rx(1'b0, 1'b0, 4'h4, 4'h5, 7'h40, 1'b0, 4'h0, 0, 1'b1, 1'b0);
		for (int k = 0; k < 8; k++) begin
			wr(GL, k[2] ? SR : 32'h0);
			rx(k[1], k[0], 4'h8, 4'h0, 7'h40, k[1] == k[0] && (!k[1] || k[2]), 4'h8, 8, 1'b0, 1'b0);
		end
		wr(GL, CK);
		rx(1'b0, 1'b0, 4'h8, 4'h0, 7'h04, 1'b0, 4'h0, 0, 1'b0, 1'b1);
		wr(GL, CK | OV);
		rx(1'b0, 1'b0, 4'h8, 4'h0, 7'h04, 1'b1, 4'h8, 4, 1'b0, 1'b0);
		wr(GL, CK | RP | OV);
		rx(1'b0, 1'b0, 4'h8, 4'h6, 7'h04, 1'b1, 4'h6, 4, 1'b0, 1'b0);
		$display("test receive path done");
		wr(GL, 32'h0);
		tsrun(16'h0008);
		cap(0, 1);
		wr(GL, C1);
		cap(1, 0);
		wr(GL, C2);
		rx_is_fd <= 1'b1;
		cap(2, 0);
		rx_is_fd <= 1'b0;
		cap(0, 2);
		ev(3, t0);
		chk({tx_history_write, tx_history_stamp}, {1'b1, t0});
		wr(GL, TB);
		classical_only <= 1'b1;
		tsrun(16'h0002);
		ch_halt <= 1'b1;
		tsrun(16'h0000);
		ch_halt <= 1'b0;
		ch_reset <= 1'b1;
		tsrun(16'h0000);
		ch_reset <= 1'b0;
		classical_only <= 1'b0;
		tsrun(16'h0000);
		ch_halt <= 1'b1;
		wr(GL, 32'h0);
		tsrun(16'h0008);
		for (i = 0; i < 70000; i++) begin
			@(posedge pclk);
			if (timestamp === 16'hffff) break;
		end
		if (i == 70000) tmo();
		#1 chk(timestamp, 16'h0000);
		$display("test timestamp done");
		wr(GH, 32'h00000003);
		gap(3);
		wr(FC, 32'h1 << cgrx_pkg::ITV_TEN_BIT);
		gap(30);
		wr(GH, 32'h00000000);
		gap(10);
		wr(FC, 32'h1 << cgrx_pkg::ITV_SRC_BIT);
		gap(0);
		$display("test interval done");
		wr(GL, RX);
		ev(4, t0);
		chk({protocol_exception, form_error_frame}, 2'b10);
		wr(GL, 32'h0);
		ev(4, t0);
		chk({protocol_exception, form_error_frame}, 2'b01);
		apb(1'b0, cgrx_pkg::STATUS_OFS, 32'h0, q, e);
		chk({q[cgrx_pkg::ST_PEX_BIT], q[cgrx_pkg::ST_OVF_BIT], q[cgrx_pkg::ST_DLC_ERR_BIT]}, 3'b111);
		// Sticky flags clear on a write of ones
		apb(1'b1, cgrx_pkg::STATUS_OFS, 32'h7 << cgrx_pkg::ST_DLC_ERR_BIT, q, e);
		apb(1'b0, cgrx_pkg::STATUS_OFS, 32'h0, q, e);
		chk(q[cgrx_pkg::ST_PEX_BIT:cgrx_pkg::ST_DLC_ERR_BIT], 3'b000);
		$display("test exception done");
		stop_test();
	end
endmodule : cgrx_top_tb
